// *** logic/eac_pkg.sv ***
// Purpose: Shared constants, register map and carrier types for energy accumulation control.
// Assumes: One 100 MHz clock; the register port is a same-clock word-wide strobe port.
// Notes:   All numbers used by more than one file live here.

package eac_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned EAC_SYS_CLK_HZ  = 100_000_000;
  localparam int unsigned EAC_DSP_RATE_HZ = 8_000;
  localparam int unsigned EAC_TICK_DIV    = EAC_SYS_CLK_HZ / EAC_DSP_RATE_HZ;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned EAC_SAMPLE_W = 16;
  localparam int unsigned EAC_ADDR_W   = 8;
  localparam int unsigned EAC_DATA_W   = 32;
  localparam int unsigned EAC_POWER_W  = 34;
  localparam int unsigned EAC_THR_W    = 48;
  localparam int unsigned EAC_THR_HALF = 24;
  localparam int unsigned EAC_CF_W     = 36;
  localparam int unsigned EAC_PHASES   = 3;
  localparam int unsigned EAC_VAR_SHIFT = 4;

  // ****************************************************************
  // Register indices
  // ****************************************************************
  localparam logic [7:0] EAC_OFS_ACC_CFG  = 8'h00;
  localparam logic [7:0] EAC_OFS_LC_CFG   = 8'h01;
  localparam logic [7:0] EAC_OFS_HALF_CYC = 8'h02;
  localparam logic [7:0] EAC_OFS_EVENT_STATUS_0  = 8'h03;
  localparam logic [7:0] EAC_OFS_EVENT_MASK_0    = 8'h04;
  localparam logic [7:0] EAC_OFS_THR_LO   = 8'h05;
  localparam logic [7:0] EAC_OFS_THR_HI   = 8'h06;
  localparam logic [7:0] EAC_OFS_ENERGY   = 8'h08;
  localparam logic [7:0] EAC_OFS_REACT    = 8'h0c;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned EAC_CF_MODE_LSB = 0;
  localparam int unsigned EAC_WIRING_LSB  = 4;
  localparam int unsigned EAC_LC_EN_BIT   = 0;
  localparam int unsigned EAC_ZX_SEL_LSB  = 3;
  localparam int unsigned EAC_COR_EN_BIT  = 6;
  localparam int unsigned EAC_LC_DONE_BIT = 5;

  // ****************************************************************
  // Encodings and reset values
  // ****************************************************************
  localparam logic [1:0]  EAC_WIRE_OWN      = 2'h0;
  localparam logic [1:0]  EAC_WIRE_ZERO     = 2'h1;
  localparam logic [1:0]  EAC_WIRE_NEG_AC   = 2'h2;
  localparam logic [1:0]  EAC_WIRE_NEG_A    = 2'h3;
  localparam logic [1:0]  EAC_CF_ABSOLUTE   = 2'h1;
  localparam logic [1:0]  EAC_RST_CF_MODE   = 2'h0;
  localparam logic [1:0]  EAC_RST_WIRING    = 2'h0;
  localparam logic [2:0]  EAC_RST_ZX_SEL    = 3'h7;
  localparam logic [15:0] EAC_RST_HALF_CYC  = 16'hffff;
  localparam logic [47:0] EAC_RST_THR       = 48'h000000000000;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic signed [EAC_SAMPLE_W-1:0] volt;
    logic signed [EAC_SAMPLE_W-1:0] curr;
    logic signed [EAC_SAMPLE_W-1:0] curr_q;
  } eac_phase_s;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [EAC_ADDR_W-1:0] addr;
    logic [EAC_DATA_W-1:0] wdata;
  } eac_req_s;

  typedef struct packed {
    logic signed [EAC_THR_W:0] acc;
    logic                      pulse;
    logic                      neg;
  } eac_stage_s;

  typedef struct packed {
    logic [15:0]                             tick_cnt;
    logic                                    tick;
    logic [1:0]                              cf_mode;
    logic [1:0]                              wiring;
    logic                                    lc_en;
    logic [2:0]                              zx_sel;
    logic                                    cor_en;
    logic [15:0]                             half_cyc;
    logic [15:0]                             zx_cnt;
    logic                                    lc_done;
    logic                                    lc_mask;
    logic [EAC_THR_W-1:0]                    thr;
    logic [EAC_PHASES-1:0][EAC_DATA_W-1:0]   acc;
    logic [EAC_PHASES-1:0][EAC_DATA_W-1:0]   energy;
    logic [EAC_PHASES-1:0][EAC_DATA_W-1:0]   react;
    logic signed [EAC_CF_W-1:0]              cf_power;
    logic [EAC_DATA_W-1:0]                   rdata;
    logic                                    rvalid;
    logic                                    irq_n;
  } eac_state_s;

endpackage : eac_pkg

// *** logic/eac_first_stage.sv ***
// Purpose: First-stage energy integrator for one phase.
// Assumes: tick_i is a one-cycle pulse at the DSP rate; reset is already synchronised.
// Notes:   A zero threshold stops pulse generation rather than pulsing every tick.

`timescale 1ns/1ps

module eac_first_stage
  import eac_pkg::*;
(
  // Clock and reset
  input  wire logic                          clock_i,
  input  wire logic                          rst_n_i,
  // Power sample
  input  wire logic                          tick_i,
  input  wire logic signed [EAC_POWER_W-1:0] power_i,
  input  wire logic [EAC_THR_W-1:0]          thr_i,
  // Energy pulse
  output logic                               pulse_o,
  output logic                               neg_o
);

  eac_stage_s s_q;
  eac_stage_s s_d;

  always_comb begin
    logic signed [EAC_THR_W:0] sum;
    logic signed [EAC_THR_W:0] thr_s;
    sum   = '0;
    thr_s = '0;
    s_d       = s_q;
    s_d.pulse = 1'b0;
    if (tick_i) begin
      // The wide accumulator keeps the residue signed, so negative energy is subtracted.
      sum   = s_q.acc + (EAC_THR_W+1)'(power_i);
      thr_s = $signed({1'b0, thr_i});
      if ((thr_i != '0) && (sum >= thr_s)) begin
        s_d.pulse = 1'b1;
        s_d.neg   = 1'b0;
        s_d.acc   = sum - thr_s;
      end else if ((thr_i != '0) && (sum <= -thr_s)) begin
        s_d.pulse = 1'b1;
        s_d.neg   = 1'b1;
        s_d.acc   = sum + thr_s;
      end else begin
        s_d.acc = sum;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pulse_o = s_q.pulse;
  assign neg_o   = s_q.neg;

endmodule : eac_first_stage

// *** logic/eac_top.sv ***
// Purpose: Per-phase active energy accumulation, line-cycle mode and reactive samples.
// Assumes: Samples and zero-cross pulses come from same-clock DSP logic.
// Notes:   Register port is a word-wide strobe port behind the serial interface.

`timescale 1ns/1ps

module eac_top
  import eac_pkg::*;
#(
  parameter int unsigned TICK_DIV_CYC = EAC_TICK_DIV
) (
  // Clock and reset
  input  wire logic                   clock_i,
  input  wire logic                   arst_n_i,
  // Sample inputs from the DSP front end
  input  eac_phase_s [EAC_PHASES-1:0] phase_i,
  input  wire logic [EAC_PHASES-1:0]  zx_pulse_i,
  // Register port
  input  eac_req_s                    req_i,
  output logic [EAC_DATA_W-1:0]       rdata_o,
  output logic                        rvalid_o,
  // Outputs
  output logic signed [EAC_CF_W-1:0]  cf_power_o,
  output logic                        interrupt_out_0_n_o
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic logic signed [EAC_POWER_W-1:0] eac_mul(
    input logic signed [EAC_SAMPLE_W+1:0] v,
    input logic signed [EAC_SAMPLE_W-1:0] i
  );
    eac_mul = EAC_POWER_W'(v * i);
  endfunction : eac_mul

  function automatic logic signed [EAC_CF_W-1:0] eac_cf_term(
    input logic signed [EAC_POWER_W-1:0] p,
    input logic [1:0]                    mode
  );
    logic signed [EAC_CF_W-1:0] w;
    w = EAC_CF_W'(p);
    if ((mode == EAC_CF_ABSOLUTE) && (p < 0)) begin
      w = -w;
    end
    eac_cf_term = w;
  endfunction : eac_cf_term

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Power products and first stage
  // ****************************************************************
  eac_state_s                                s_q;
  eac_state_s                                s_d;
  logic signed [EAC_POWER_W-1:0]             power [EAC_PHASES];
  logic signed [EAC_SAMPLE_W+1:0]            volt_b;
  logic [EAC_PHASES-1:0]                     pulse;
  logic [EAC_PHASES-1:0]                     neg;

  always_comb begin
    volt_b = (EAC_SAMPLE_W+2)'(phase_i[1].volt);
    if (s_q.wiring == EAC_WIRE_NEG_AC) begin
      volt_b = -(EAC_SAMPLE_W+2)'(phase_i[0].volt) - (EAC_SAMPLE_W+2)'(phase_i[2].volt);
    end else if (s_q.wiring == EAC_WIRE_NEG_A) begin
      volt_b = -(EAC_SAMPLE_W+2)'(phase_i[0].volt);
    end
    power[0] = eac_mul((EAC_SAMPLE_W+2)'(phase_i[0].volt), phase_i[0].curr);
    power[2] = eac_mul((EAC_SAMPLE_W+2)'(phase_i[2].volt), phase_i[2].curr);
    if (s_q.wiring == EAC_WIRE_ZERO) begin
      power[1] = '0;
    end else begin
      power[1] = eac_mul(volt_b, phase_i[1].curr);
    end
  end

  for (genvar ph = 0; ph < EAC_PHASES; ph++) begin : g_stage
    eac_first_stage u_stage (
      .clock_i (clock_i),
      .rst_n_i (rst_n),
      .tick_i  (s_q.tick),
      .power_i (power[ph]),
      .thr_i   (s_q.thr),
      .pulse_o (pulse[ph]),
      .neg_o   (neg[ph])
    );
  end

  // ****************************************************************
  // Accumulation, line cycle and register port
  // ****************************************************************
  always_comb begin
    logic                  zx_hit;
    logic                  period_end;
    logic [15:0]           zx_next;
    logic [EAC_DATA_W-1:0] delta [EAC_PHASES];
    logic [EAC_DATA_W-1:0] acc_upd [EAC_PHASES];
    logic signed [EAC_CF_W-1:0] cf_sum;
    logic signed [31:0]    q_prod;
    zx_hit     = 1'b0;
    period_end = 1'b0;
    zx_next    = '0;
    cf_sum     = '0;
    q_prod     = '0;
    for (int ph = 0; ph < EAC_PHASES; ph++) begin
      delta[ph]   = '0;
      acc_upd[ph] = '0;
    end

    s_d        = s_q;
    s_d.tick   = 1'b0;
    s_d.rvalid = 1'b0;

    // DSP rate enable.
    if (s_q.tick_cnt == 16'(TICK_DIV_CYC - 1)) begin
      s_d.tick_cnt = '0;
      s_d.tick     = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
    end

    // Crossings from several phases in one cycle count once.
    zx_hit  = |(zx_pulse_i & s_q.zx_sel);
    zx_next = s_q.zx_cnt + 16'h0001;
    if (zx_hit) begin
      // The counter advances whether or not line-cycle mode is on.
      if ((s_q.half_cyc != 16'h0000) && (zx_next == s_q.half_cyc)) begin
        period_end = 1'b1;
        s_d.zx_cnt = '0;
      end else begin
        s_d.zx_cnt = zx_next;
      end
    end

    // Second stage: pulses step the 32-bit accumulators, wrapping freely.
    for (int ph = 0; ph < EAC_PHASES; ph++) begin
      if (pulse[ph]) begin
        delta[ph] = neg[ph] ? 32'hffffffff : 32'h00000001;
      end
      acc_upd[ph] = s_q.acc[ph] + delta[ph];
      s_d.acc[ph] = acc_upd[ph];
    end

    if (period_end && s_q.lc_en) begin
      for (int ph = 0; ph < EAC_PHASES; ph++) begin
        s_d.energy[ph] = acc_upd[ph];
        s_d.acc[ph]    = '0;
      end
    end

    // Frequency output power and reactive samples refresh every DSP tick.
    if (s_q.tick) begin
      for (int ph = 0; ph < EAC_PHASES; ph++) begin
        cf_sum = cf_sum + eac_cf_term(power[ph], s_q.cf_mode);
        q_prod = 32'(phase_i[ph].volt * phase_i[ph].curr_q);
        s_d.react[ph] = 32'(q_prod >>> EAC_VAR_SHIFT);
      end
      s_d.cf_power = cf_sum;
    end

    // Register writes.
    if (req_i.wr) begin
      if (req_i.addr == EAC_OFS_ACC_CFG) begin
        s_d.cf_mode = req_i.wdata[EAC_CF_MODE_LSB +: 2];
        s_d.wiring  = req_i.wdata[EAC_WIRING_LSB +: 2];
      end else if (req_i.addr == EAC_OFS_LC_CFG) begin
        s_d.lc_en  = req_i.wdata[EAC_LC_EN_BIT];
        s_d.zx_sel = req_i.wdata[EAC_ZX_SEL_LSB +: 3];
        s_d.cor_en = req_i.wdata[EAC_COR_EN_BIT];
      end else if (req_i.addr == EAC_OFS_HALF_CYC) begin
        s_d.half_cyc = req_i.wdata[15:0];
        if (s_q.lc_en) begin
          s_d.zx_cnt = '0;
        end
      end else if (req_i.addr == EAC_OFS_EVENT_STATUS_0) begin
        if (req_i.wdata[EAC_LC_DONE_BIT]) begin
          s_d.lc_done = 1'b0;
        end
      end else if (req_i.addr == EAC_OFS_EVENT_MASK_0) begin
        s_d.lc_mask = req_i.wdata[EAC_LC_DONE_BIT];
      end else if (req_i.addr == EAC_OFS_THR_LO) begin
        s_d.thr[EAC_THR_HALF-1:0] = req_i.wdata[EAC_THR_HALF-1:0];
      end else if (req_i.addr == EAC_OFS_THR_HI) begin
        s_d.thr[EAC_THR_W-1:EAC_THR_HALF] = req_i.wdata[EAC_THR_HALF-1:0];
      end
    end

    // A new period end beats a clear in the same cycle.
    if (period_end && s_q.lc_en) begin
      s_d.lc_done = 1'b1;
    end

    // Register reads answer one cycle after the strobe.
    if (req_i.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = '0;
      if (req_i.addr == EAC_OFS_ACC_CFG) begin
        s_d.rdata[EAC_CF_MODE_LSB +: 2] = s_q.cf_mode;
        s_d.rdata[EAC_WIRING_LSB +: 2]  = s_q.wiring;
      end else if (req_i.addr == EAC_OFS_LC_CFG) begin
        s_d.rdata[EAC_LC_EN_BIT]        = s_q.lc_en;
        s_d.rdata[EAC_ZX_SEL_LSB +: 3]  = s_q.zx_sel;
        s_d.rdata[EAC_COR_EN_BIT]       = s_q.cor_en;
      end else if (req_i.addr == EAC_OFS_HALF_CYC) begin
        s_d.rdata[15:0] = s_q.half_cyc;
      end else if (req_i.addr == EAC_OFS_EVENT_STATUS_0) begin
        s_d.rdata[EAC_LC_DONE_BIT] = s_q.lc_done;
      end else if (req_i.addr == EAC_OFS_EVENT_MASK_0) begin
        s_d.rdata[EAC_LC_DONE_BIT] = s_q.lc_mask;
      end else if (req_i.addr == EAC_OFS_THR_LO) begin
        s_d.rdata[EAC_THR_HALF-1:0] = s_q.thr[EAC_THR_HALF-1:0];
      end else if (req_i.addr == EAC_OFS_THR_HI) begin
        s_d.rdata[EAC_THR_HALF-1:0] = s_q.thr[EAC_THR_W-1:EAC_THR_HALF];
      end else begin
        for (int ph = 0; ph < EAC_PHASES; ph++) begin
          if (req_i.addr == EAC_OFS_ENERGY + 8'(ph)) begin
            if (s_q.lc_en) begin
              // Line-cycle results are only replaced at period end.
              s_d.rdata = s_q.energy[ph];
            end else begin
              s_d.rdata      = s_q.acc[ph];
              s_d.energy[ph] = s_q.acc[ph];
              if (s_q.cor_en) begin
                // A pulse landing in the read cycle is kept, not lost.
                s_d.acc[ph] = delta[ph];
              end
            end
          end else if (req_i.addr == EAC_OFS_REACT + 8'(ph)) begin
            s_d.rdata = s_q.react[ph];
          end
        end
      end
    end

    s_d.irq_n = ~(s_d.lc_done & s_d.lc_mask);
  end

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.cf_mode  <= EAC_RST_CF_MODE;
      s_q.wiring   <= EAC_RST_WIRING;
      s_q.zx_sel   <= EAC_RST_ZX_SEL;
      s_q.half_cyc <= EAC_RST_HALF_CYC;
      s_q.thr      <= EAC_RST_THR;
      s_q.irq_n    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o             = s_q.rdata;
  assign rvalid_o            = s_q.rvalid;
  assign cf_power_o          = s_q.cf_power;
  assign interrupt_out_0_n_o = s_q.irq_n;

endmodule : eac_top

// *** test/eac_checker.sv ***
// Purpose: Port-level assertions for energy accumulation control.
// Assumes: Sees only the top ports; the raw async reset disables all checks.
// Notes:   Helper flops copy config writes so that checks know the mode.

`timescale 1ns/1ps

module eac_checker
  import eac_pkg::*;
#(
  parameter int unsigned TICK_DIV_CYC = EAC_TICK_DIV
) (
  // Watched ports
  input  wire logic                          clock_i,
  input  wire logic                          arst_n_i,
  input  eac_phase_s [EAC_PHASES-1:0]        phase_i,
  input  wire logic [EAC_PHASES-1:0]         zx_pulse_i,
  input  eac_req_s                           req_i,
  input  wire logic [EAC_DATA_W-1:0]         rdata_o,
  input  wire logic                          rvalid_o,
  input  wire logic signed [EAC_CF_W-1:0]    cf_power_o,
  input  wire logic                          interrupt_out_0_n_o
);
  // ****************************************************************
  // Mode tracking
  // ****************************************************************
  logic [1:0] mode_q;
  logic [2:0] sel_q;
  logic       en_q;
  logic       wr_st;
  logic       wr_mk;
  logic [15:0] abs_age_q;

  assign wr_st = req_i.wr && req_i.addr == EAC_OFS_EVENT_STATUS_0 && req_i.wdata[EAC_LC_DONE_BIT];
  assign wr_mk = req_i.wr && req_i.addr == EAC_OFS_EVENT_MASK_0;

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_q <= EAC_RST_CF_MODE;
      sel_q  <= EAC_RST_ZX_SEL;
      en_q   <= 1'b0;
    end else if (req_i.wr) begin
      if (req_i.addr == EAC_OFS_ACC_CFG) begin
        mode_q <= req_i.wdata[1:0];
      end
      if (req_i.addr == EAC_OFS_LC_CFG) begin
        sel_q <= req_i.wdata[5:3];
        en_q  <= req_i.wdata[0];
      end
    end
  end

  // Absolute mode must have lasted one full tick before the output can be trusted.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      abs_age_q <= 16'h0000;
    end else if (req_i.wr && req_i.addr == EAC_OFS_ACC_CFG) begin
      abs_age_q <= 16'h0000;
    end else if (mode_q == EAC_CF_ABSOLUTE && abs_age_q != 16'hffff) begin
      abs_age_q <= abs_age_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  chk_rd_answer: assert property (rvalid_o == $past(req_i.rd))
    else $error("read answer pulse misplaced");
  chk_half_width: assert property (
    req_i.rd && req_i.addr == EAC_OFS_HALF_CYC |=> rdata_o[31:16] == 16'h0000)
    else $error("half cycle count wider than 16 bits");
  chk_react_sign: assert property (
    req_i.rd && req_i.addr[7:2] == 6'h03 && req_i.addr[1:0] != 2'h3
    |=> rdata_o[31:27] == 5'h00 || rdata_o[31:27] == 5'h1f)
    else $error("reactive sample not sign extended");
  chk_status_irq: assert property (
    req_i.rd && !req_i.wr && req_i.addr == EAC_OFS_EVENT_STATUS_0 && !interrupt_out_0_n_o
    |=> rdata_o[EAC_LC_DONE_BIT])
    else $error("interrupt low without done flag");
  chk_clear_irq: assert property (wr_st && zx_pulse_i == 3'h0 |=> interrupt_out_0_n_o)
    else $error("done clear left interrupt low");
  chk_irq_rise: assert property (
    $rose(interrupt_out_0_n_o) |-> $past(wr_st) || $past(wr_mk))
    else $error("interrupt rose without clear");
  chk_irq_fall: assert property (
    $fell(interrupt_out_0_n_o) |-> $past(|(zx_pulse_i & sel_q)) || $past(wr_mk))
    else $error("interrupt fell without selected crossing");
  chk_fall_enabled: assert property (
    $fell(interrupt_out_0_n_o) && !$past(wr_mk) |-> $past(en_q))
    else $error("period end while line cycle disabled");
  chk_abs_sign: assert property (
    mode_q == EAC_CF_ABSOLUTE && abs_age_q >= 16'(TICK_DIV_CYC)
    |-> !cf_power_o[EAC_CF_W-1])
    else $error("absolute frequency power negative");

endmodule : eac_checker

bind eac_top eac_checker #(.TICK_DIV_CYC(TICK_DIV_CYC)) u_chk (
  .clock_i(clock_i), .arst_n_i(arst_n_i), .phase_i(phase_i), .zx_pulse_i(zx_pulse_i),
  .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .cf_power_o(cf_power_o),
  .interrupt_out_0_n_o(interrupt_out_0_n_o));

// *** test/eac_host_model.sv ***
// Purpose: Host controller model driving the register strobe port.
// Assumes: Requests change 1 ns after a rising edge and last one cycle.
// Notes:   Read data is taken in the cycle after the read strobe edge.

`timescale 1ns/1ps

module eac_host_model
  import eac_pkg::*;
(
  // Clock
  input  wire logic                  clock_i,
  // Register port
  input  wire logic [EAC_DATA_W-1:0] rdata_i,
  output eac_req_s                   req_o
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial req_o = '0;

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    v = d;
    // Calibration counts a single phase and never clears on read.
    if (a == EAC_OFS_LC_CFG && v[EAC_LC_EN_BIT]) begin
      v[EAC_COR_EN_BIT] = 1'b0;
      v[5:3] = v[5:3] & (~v[5:3] + 3'h1);
    end
    @(posedge clock_i);
    #1 req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge clock_i);
    #1 req_o = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_i);
    #1 req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_i);
    #1 d = rdata_i;
    req_o = '0;
  endtask : rd

  task automatic clear_done();
    wr(EAC_OFS_EVENT_STATUS_0, 32'h1 << EAC_LC_DONE_BIT);
  endtask : clear_done

endmodule : eac_host_model

// *** test/eac_top_tb.sv ***
// Purpose: Self-checking bench for energy accumulation control.
// Assumes: Tick divider shortened to 8 cycles; a host model drives the port.
// Notes:   Energy counts rely on exactly one pulse per tick for each phase.

`timescale 1ns/1ps

module eac_top_tb
  import eac_pkg::*;
;
  // ****************************************************************
  // Bench
  // ****************************************************************
  localparam int unsigned DIV = 8;
  typedef struct packed {
    logic [7:0]  wa;
    logic [31:0] wd;
    logic [7:0]  ra;
    logic [31:0] rv;
    logic [35:0] cf;
  } eac_row_s;
  localparam eac_row_s ROWS [10] = '{
    '{8'h00, 32'h00, 8'h0c, 32'h00000064, 36'h0c8},
    '{8'h00, 32'h10, 8'h0d, 32'hffffffe7, 36'h190},
    '{8'h00, 32'h20, 8'h0e, 32'h00000028, 36'h370},
    '{8'h00, 32'h30, 8'h00, 32'h00000030, 36'h320},
    '{8'h00, 32'h01, 8'h07, 32'h00000000, 36'h258},
    '{8'h00, 32'h11, 8'h06, 32'h00000000, 36'h190},
    '{8'h00, 32'h21, 8'h05, 32'h00000064, 36'h370},
    '{8'h00, 32'h31, 8'h01, 32'h00000048, 36'h320},
    '{8'h00, 32'h02, 8'h04, 32'h00000020, 36'h0c8},
    '{8'h02, 32'h1ffff, 8'h02, 32'h0000ffff, 36'h0c8}};

  logic                        clk;
  logic                        arst_n;
  eac_phase_s [EAC_PHASES-1:0] phase;
  logic [2:0]                  zx;
  eac_req_s                    req;
  logic [31:0]                 rdata;
  logic                        rvalid;
  logic signed [35:0]          cf;
  logic                        irq_n;
  logic [31:0]                 d;
  int                          cyc;
  int                          t0;
  int                          n_errors;
  int                          n_checks;

  eac_top #(.TICK_DIV_CYC(DIV)) dut (
    .clock_i(clk), .arst_n_i(arst_n), .phase_i(phase), .zx_pulse_i(zx), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .cf_power_o(cf), .interrupt_out_0_n_o(irq_n));
  eac_host_model host (.clock_i(clk), .rdata_i(rdata), .req_o(req));

  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // The crossing lands on the edge after cycle count t is reached.
  task automatic zx_at(input int t, input logic [2:0] m);
    for (int k = 0; k < 2000 && cyc < t; k++) begin
      @(posedge clk);
      #1;
    end
    if (cyc < t) begin
      n_errors++;
      conclude();
    end
    zx = m;
    @(posedge clk);
    #1 zx = 3'h0;
  endtask : zx_at

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    conclude();
  end

  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    zx = 3'h0;
    cyc = 0;
    phase[0] = {16'h0064, 16'h0003, 16'h0010};
    phase[1] = {16'h0032, 16'hfffc, 16'hfff8};
    phase[2] = {16'h0014, 16'h0005, 16'h0020};
    repeat (3) @(posedge clk);
    #1 arst_n = 1'b1;
    repeat (3) @(posedge clk);
    host.rd(EAC_OFS_LC_CFG, d);
    check(d, 36'h38);
    check(rvalid, 36'h1);
    host.rd(EAC_OFS_HALF_CYC, d);
    check(d, 36'hffff);
    check(irq_n, 36'h1);
    $display("test reset done");
    host.wr(EAC_OFS_THR_LO, 32'h64);
    host.wr(EAC_OFS_EVENT_MASK_0, 32'h20);
    zx_at(cyc + 2, 3'h1);
    host.wr(EAC_OFS_LC_CFG, 32'h39);
    host.wr(EAC_OFS_HALF_CYC, 32'h2);
    zx_at(cyc + 2, 3'h2);
    zx_at(cyc + 2, 3'h1);
    check(irq_n, 36'h1);
    zx_at(cyc + 2, 3'h1);
    t0 = cyc;
    check(irq_n, 36'h0);
    host.rd(EAC_OFS_EVENT_STATUS_0, d);
    check(d, 36'h20);
    host.clear_done();
    check(irq_n, 36'h1);
    zx_at(t0 + 39, 3'h1);
    zx_at(t0 + 79, 3'h1);
    // Second pass spans ticks, so it also shows that reads do not clear.
    for (int p = 0; p < 6; p++) begin
      host.rd(8'(EAC_OFS_ENERGY + p % 3), d);
      check(d, (p % 3 == 1) ? 36'hfffffff6 : 36'h0a);
    end
    host.clear_done();
    $display("test line cycle done");
    host.wr(EAC_OFS_LC_CFG, 32'h48);
    host.rd(EAC_OFS_ENERGY, d);
    repeat (38) @(posedge clk);
    host.rd(EAC_OFS_ENERGY, d);
    check(d, 36'h5);
    $display("test clear on read done");
    // The counter keeps running while line-cycle mode is off, so this period is short.
    zx_at(cyc + 2, 3'h1);
    host.wr(EAC_OFS_LC_CFG, 32'h09);
    check(irq_n, 36'h1);
    zx_at(cyc + 2, 3'h1);
    check(irq_n, 36'h0);
    host.clear_done();
    host.wr(EAC_OFS_LC_CFG, 32'h48);
    $display("test free counter done");
    foreach (ROWS[r]) begin
      host.wr(ROWS[r].wa, ROWS[r].wd);
      repeat (3 * DIV) @(posedge clk);
      #1;
      check(cf, ROWS[r].cf);
      host.rd(ROWS[r].ra, d);
      check(d, 36'(ROWS[r].rv));
    end
    $display("test table done");
    // A strongly negative phase B makes absolute and signed sums differ in sign.
    phase[1].curr = 16'hff9c;
    host.wr(EAC_OFS_ACC_CFG, 32'h00);
    repeat (3 * DIV) @(posedge clk);
    #1;
    check(cf, 36'hfffffee08);
    host.wr(EAC_OFS_ACC_CFG, 32'h01);
    repeat (3 * DIV) @(posedge clk);
    #1;
    check(cf, 36'h000001518);
    $display("test absolute sign done");
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(cf, 36'h0);
    check(rvalid, 36'h0);
    arst_n = 1'b1;
    repeat (3) @(posedge clk);
    host.rd(EAC_OFS_ACC_CFG, d);
    check(d, 36'h0);
    $display("test mid reset done");
    conclude();
  end

endmodule : eac_top_tb
